// ===== bench/mmd_decoder_tb.sv
/* Bench for both decoder variants; data scored on the small one.
 Assumes the special register model. */
`timescale 1ns/10ps
module mmd_decoder_tb;
    reg clk_i = 0, nrst_i = 0, pc_load_i = 0, pc_inc_i = 0, int_take_i = 0;
    reg acc_i = 0, acc_write_i = 0, acc_indirect_i = 0, rd_q = 0, rd_q2 = 0;
    reg  [12:0] pc_load_val_i = 0;
    reg  [6:0]  acc_dir_addr_i = 0;
    reg  [7:0]  file_select_pointer_i = 0, status_i = 0, wdata_i = 0, mem [0:127], q [$];
    wire [7:0]  sfr_rdata_i, data_addr_o, rdata_o;
    wire [12:0] pc_o, prog_addr_o;
    wire        sfr_sel_o, sfr_write_o, gpr_hit_o;
    wire [12:0] pc_l, prog_addr_l;
    wire [7:0]  data_addr_l, rdata_l;
    wire        sfr_sel_l, sfr_write_l, gpr_hit_l;
    integer     n_errors = 0, compares = 0, seed = 39132, i;
    always #10 clk_i = ~clk_i;
    mmd_decoder #(.LARGE(0)) dut (.*);
    mmd_decoder #(.LARGE(1)) dut_large (.clk_i(clk_i), .nrst_i(nrst_i), .pc_load_i(pc_load_i),
        .pc_load_val_i(pc_load_val_i), .pc_inc_i(pc_inc_i), .int_take_i(int_take_i),
        .acc_i(acc_i), .acc_write_i(acc_write_i), .acc_indirect_i(acc_indirect_i),
        .acc_dir_addr_i(acc_dir_addr_i), .file_select_pointer_i(file_select_pointer_i),
        .status_i(status_i), .wdata_i(wdata_i), .sfr_rdata_i(sfr_rdata_i), .pc_o(pc_l),
        .prog_addr_o(prog_addr_l), .data_addr_o(data_addr_l), .sfr_sel_o(sfr_sel_l),
        .sfr_write_o(sfr_write_l), .gpr_hit_o(gpr_hit_l), .rdata_o(rdata_l));
    mmd_sfr_model u_sfr (.clk_i(clk_i), .sel_i(sfr_sel_o), .addr_i(data_addr_o),
                         .rdata_o(sfr_rdata_i));
    task check(input [12:0] seen, input [12:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp)
            begin
                n_errors = n_errors + 1;
                $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task conclude;
        begin
            if (n_errors == 0 && compares > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task access(input w, input ind, input [7:0] a, input [7:0] dat);
        begin
            acc_i <= 1; acc_write_i <= w; acc_indirect_i <= ind; wdata_i <= dat;
            file_select_pointer_i <= a; acc_dir_addr_i <= a[6:0];
            status_i <= {2'b00, ind ^ a[7], 5'h00};
            if (!w)
                q.push_back(a[6:0] <= 7'h1f ? a ^ 8'h5a
                    : a >= (a[7] ? 8'hf0 : 8'h40) ? mem[a[6:0]] : 8'h00);
            else if (a >= (a[7] ? 8'hf0 : 8'h40))
                mem[a[6:0]] = dat;
            @(posedge clk_i) #1;
        end
    endtask
    always @(posedge clk_i) rd_q <= acc_i && !acc_write_i && nrst_i;
    always @(posedge clk_i) rd_q2 <= rd_q;
    always @(negedge clk_i) if (rd_q2) check(rdata_o, q.pop_front());
    initial
    begin
        #100000 n_errors = n_errors + 1;
        conclude;
    end
    initial
    begin
        repeat (20) @(posedge clk_i);
        #1 nrst_i <= 1;
        pc_load_val_i <= 13'h1ffe;
        pc_load_i <= 1;
        check(pc_o, 13'h0000);
        @(posedge clk_i) #1 pc_load_i <= 0;
        pc_inc_i <= 1;
        check(prog_addr_o, 13'h03fe);
        check(prog_addr_l, 13'h07fe);
        repeat (2) @(posedge clk_i);
        #1 check(pc_o, 13'h0000);
        int_take_i <= 1;
        @(posedge clk_i) #1 check(prog_addr_o, 13'h0004);
        int_take_i <= 0;
        pc_inc_i <= 0;
        for (i = 64; i < 128; i = i + 1) access(1, i[0], i[7:0], $random(seed));
        for (i = 0; i < 300; i = i + 1) access($random(seed), $random(seed), $random(seed),
                                               $random(seed));
        access(0, 0, 8'hf5, 8'h00);
        acc_i <= 0;
        repeat (3) @(posedge clk_i);
        conclude;
    end
endmodule // mmd_decoder_tb

// ===== bench/mmd_props_properties.sv
/* Port checker for the decoder.
 Assumes the bind below. */
`timescale 1ns/10ps
module mmd_props #(parameter LARGE = 0) (
    input wire clk_i, nrst_i, pc_load_i, pc_inc_i, int_take_i, acc_i, acc_write_i,
    input wire acc_indirect_i, sfr_sel_o, sfr_write_o, gpr_hit_o,
    input wire [12:0] pc_load_val_i, pc_o, prog_addr_o,
    input wire [6:0] acc_dir_addr_i,
    input wire [7:0] file_select_pointer_i, status_i, data_addr_o, rdata_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    wire [7:0] d = data_addr_o;
    sequence s_dir;
        acc_i && !acc_indirect_i;
    endsequence
    sequence s_rd_miss;
        (acc_i && !acc_write_i) ##1 !(sfr_sel_o || gpr_hit_o);
    endsequence
    AST_FOLD: assert property (prog_addr_o == (pc_o & (LARGE ? 13'h07ff : 13'h03ff)))
        else $error("fold");
    AST_INTV: assert property (int_take_i |=> pc_o == 13'h0004) else $error("vec");
    AST_INC: assert property (pc_inc_i && !pc_load_i && !int_take_i
        |=> pc_o == $past(pc_o) + 13'h0001) else $error("inc");
    AST_LOAD: assert property (pc_load_i && !pc_inc_i && !int_take_i
        |=> pc_o == $past(pc_load_val_i)) else $error("load");
    AST_DADDR: assert property (s_dir |=> d == {$past(status_i[5]), $past(acc_dir_addr_i)})
        else $error("direct");
    AST_IND: assert property (acc_i && acc_indirect_i |=> d == $past(file_select_pointer_i))
        else $error("pointer");
    AST_SFR: assert property (acc_i |=> sfr_sel_o == (d[6:0] <= 7'h1f)) else $error("sfr");
    AST_GPR: assert property (acc_i |=> gpr_hit_o == (d >= (d[7] ? (LARGE ? 8'ha0 : 8'hf0)
        : (LARGE ? 8'h20 : 8'h40)))) else $error("ram");
    AST_ZERO: assert property (s_rd_miss |=> rdata_o == 8'h00) else $error("zero");
    AST_SFRW: assert property (acc_i |=> sfr_write_o == (sfr_sel_o && $past(acc_write_i)))
        else $error("sfr write");
endmodule // mmd_props
bind mmd_decoder mmd_props #(.LARGE(LARGE)) u_props (.*);

// ===== bench/mmd_sfr_model.sv
/* Special register side: selected reads answer from the address.
 Assumes one clock. */
`timescale 1ns/10ps
module mmd_sfr_model (
    input  wire       clk_i,
    input  wire       sel_i,
    input  wire [7:0] addr_i,
    output wire [7:0] rdata_o
);
    reg [7:0] pat_r = 8'h00;
    // Unselected, show a moving pattern, never a stale value
    always @(posedge clk_i) pat_r <= {pat_r[6:0], ~pat_r[7]};
    assign rdata_o = sel_i ? addr_i ^ 8'h5a : pat_r;
endmodule // mmd_sfr_model

// ===== rtl/mmd_consts.vh
/*
 Constants for the memory map decoder: program space limits, vectors,
 data map boundaries. Assumes inclusion by plain Verilog-2005 files.
*/
`ifndef MMD_CONSTS_VH
`define MMD_CONSTS_VH
`define MMD_PC_W          13
`define MMD_INSTR_W       14
`define MMD_PROG_MASK_1K  13'h03ff
`define MMD_PROG_MASK_2K  13'h07ff
`define MMD_RESET_VEC     13'h0000
`define MMD_INT_VEC       13'h0004
`define MMD_SFR_TOP       7'h1f
`define MMD_GPR_LO_SMALL  7'h40
`define MMD_GPR_LO_LARGE  7'h20
`define MMD_B1_GPR_LO     7'h20
`define MMD_B1_GPR_HI     7'h6f
`define MMD_COMMON_LO     7'h70
`define MMD_RAM_DEPTH     128
`define MMD_STATUS_BANK_BIT 5
`endif

// ===== rtl/mmd_decoder.v
/*
 Memory map decoder: program address folding and vectors, data bank
 selection, special/general split, common window mirroring, zero read
 of unimplemented cells. Assumes a CPU core on the same clock that gives
 one access strobe per cycle and takes read data two cycles after it.
*/
`timescale 1ns/10ps
`include "mmd_consts.vh"
// Function
// RULE1 - 13-bit counter, 8K by 14 space
// RULE2 - Small variant: words 0 to 03FFh exist
// RULE3 - Large variant: words 0 to 07FFh exist
// RULE4 - Addresses beyond implemented space wrap around
// RULE5 - Reset vector 0000h, interrupt vector 0004h
// RULE6 - Two banks, lowest 32 are special registers
// RULE7 - Small: bank 0 40h-7Fh is RAM
// RULE8 - Large: 20h-7Fh and A0h-EFh are RAM
// RULE9 - F0h-FFh mirror bank 0 70h-7Fh
// RULE10 - Unimplemented locations read zero
// RULE11 - Bank bit selects bank 0 or 1
// RULE12 - Software keeps reserved status bits zero
// RULE13 - RAM holds 64 or 128 bytes
// RULE14 - Direct and pointer access reach every cell
// RULE15 - Direct address is bank bit over 7 bits
module mmd_decoder #(
    parameter LARGE = 0
) (
    input  wire        clk_i,
    input  wire        nrst_i,
    input  wire        pc_load_i,
    input  wire [12:0] pc_load_val_i,
    input  wire        pc_inc_i,
    input  wire        int_take_i,
    input  wire        acc_i,
    input  wire        acc_write_i,
    input  wire        acc_indirect_i,
    input  wire [6:0]  acc_dir_addr_i,
    input  wire [7:0]  file_select_pointer_i,
    input  wire [7:0]  status_i,
    input  wire [7:0]  wdata_i,
    input  wire [7:0]  sfr_rdata_i,
    output reg  [12:0] pc_o,
    output reg  [12:0] prog_addr_o,
    output reg  [7:0]  data_addr_o,
    output reg         sfr_sel_o,
    output reg         sfr_write_o,
    output reg         gpr_hit_o,
    output reg  [7:0]  rdata_o
);
    localparam [12:0] PROG_MASK = LARGE ? `MMD_PROG_MASK_2K : `MMD_PROG_MASK_1K; // RULE2 RULE3

    // Classify a bank-local address: 0 none, 1 special, 2 RAM
    function [1:0] mmd_class;
        input       bank;
        input [6:0] off;
        begin
            if (off <= `MMD_SFR_TOP)
                mmd_class = 2'h1; // RULE6
            else if (!bank && off >= (LARGE ? `MMD_GPR_LO_LARGE : `MMD_GPR_LO_SMALL))
                mmd_class = 2'h2; // RULE7 RULE8
            else if (bank && off >= `MMD_COMMON_LO)
                mmd_class = 2'h2; // RULE9
            else if (bank && LARGE && off >= `MMD_B1_GPR_LO && off <= `MMD_B1_GPR_HI)
                mmd_class = 2'h2; // RULE8
            else
                mmd_class = 2'h0;
        end
    endfunction

    // RAM index: bank 1 window folds onto bank 0 cells
    function [6:0] mmd_ram_idx;
        input       bank;
        input [6:0] off;
        begin
            if (!bank || off >= `MMD_COMMON_LO)
                mmd_ram_idx = off; // RULE9
            else
                mmd_ram_idx = off - 7'h20 + 7'h10;
        end
    endfunction

    localparam [1:0] CLS_NONE = 2'h0;
    localparam [1:0] CLS_SFR  = 2'h1;
    localparam [1:0] CLS_RAM  = 2'h2;

    reg  [12:0] pc_nxt;
    reg  [7:0]  rdata_nxt;
    wire [7:0]  eff_addr;
    wire [1:0]  cls;
    wire [6:0]  ram_idx;
    wire [7:0]  ram_q;
    wire        hit_sfr;
    wire        hit_ram;
    wire        ram_we;
    reg         rd_ram_r;
    reg         rd_sfr_r;

    // Pointer carries its own bank in bit 7; direct uses the status bit
    assign eff_addr = acc_indirect_i ? file_select_pointer_i
                    : {status_i[`MMD_STATUS_BANK_BIT], acc_dir_addr_i}; // RULE11 RULE14 RULE15
    assign cls      = mmd_class(eff_addr[7], eff_addr[6:0]);
    assign ram_idx  = mmd_ram_idx(eff_addr[7], eff_addr[6:0]);

    // Strobe qualifies every hit; an idle cycle decodes to nothing
    assign hit_sfr  = acc_i & (cls == CLS_SFR); // RULE6
    assign hit_ram  = acc_i & (cls == CLS_RAM); // RULE7 RULE8 RULE9

    // Writes to unimplemented cells never reach the array
    assign ram_we   = hit_ram & acc_write_i; // RULE10

    // Small variant uses 64 of 128 cells; indices 40h-7Fh only
    mmd_gpr_ram #(
        .DEPTH (`MMD_RAM_DEPTH),
        .AW    (7)
    ) u_ram (
        .clk_i   (clk_i),
        .we_i    (ram_we),
        .addr_i  (ram_idx),
        .wdata_i (wdata_i),
        .rdata_o (ram_q)
    ); // RULE13

    // Interrupt beats a load, a load beats an increment
    always @*
    begin
        pc_nxt = pc_o;
        if (int_take_i)
            pc_nxt = `MMD_INT_VEC; // RULE5
        else if (pc_load_i)
            pc_nxt = pc_load_val_i; // RULE1
        else if (pc_inc_i)
            pc_nxt = pc_o + 13'h0001;
    end

    // Counter keeps all 13 bits; only the fetch address is folded
    always @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            pc_o        <= `MMD_RESET_VEC; // RULE5
            prog_addr_o <= `MMD_RESET_VEC;
        end
        else
        begin
            pc_o        <= pc_nxt;
            prog_addr_o <= pc_nxt & PROG_MASK; // RULE4
        end
    end

    // Access results stand for the one cycle after the strobe
    always @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            data_addr_o <= 8'h00;
            sfr_sel_o   <= 1'b0;
            sfr_write_o <= 1'b0;
            gpr_hit_o   <= 1'b0;
            rd_ram_r    <= 1'b0;
            rd_sfr_r    <= 1'b0;
        end
        else
        begin
            data_addr_o <= eff_addr;
            sfr_sel_o   <= hit_sfr;
            sfr_write_o <= hit_sfr & acc_write_i;
            gpr_hit_o   <= hit_ram;
            rd_ram_r    <= hit_ram & ~acc_write_i;
            rd_sfr_r    <= hit_sfr & ~acc_write_i;
        end
    end

    // Choice of read source, taken while the selects stand
    always @*
    begin
        rdata_nxt = 8'h00; // RULE10
        if (rd_ram_r)
            rdata_nxt = ram_q;
        else if (rd_sfr_r)
            rdata_nxt = sfr_rdata_i;
    end

    // Output from a flop; costs one more cycle of read latency
    always @(posedge clk_i)
    begin
        if (!nrst_i)
            rdata_o <= 8'h00;
        else
            rdata_o <= rdata_nxt;
    end
endmodule // mmd_decoder

// ===== rtl/mmd_gpr_ram.v
/*
 General-purpose RAM array, one synchronous write port and a registered
 read port. Assumes the decoder gives a folded index and a write strobe.
*/
`timescale 1ns/10ps
`include "mmd_consts.vh"
module mmd_gpr_ram #(
    parameter DEPTH = `MMD_RAM_DEPTH,
    parameter AW    = 7
) (
    input  wire          clk_i,
    input  wire          we_i,
    input  wire [AW-1:0] addr_i,
    input  wire [7:0]    wdata_i,
    output reg  [7:0]    rdata_o
);
    reg [7:0] mem_r [0:DEPTH-1];

    always @(posedge clk_i)
    begin
        if (we_i)
            mem_r[addr_i] <= wdata_i;
        rdata_o <= mem_r[addr_i];
    end
endmodule // mmd_gpr_ram
